// ===== rcf_consts.vh
`ifndef RCF_CONSTS_VH
`define RCF_CONSTS_VH

// register byte offsets on the APB bus
`define RCF_OFS_CAUSE      12'h000
`define RCF_OFS_EVT_STATUS 12'h004
`define RCF_OFS_EVT_MASK   12'h008

// field positions of reset_cause_register
`define RCF_BIT_STK_HIGH   7
`define RCF_BIT_STK_LOW    6
`define RCF_BIT_UNUSED     5
`define RCF_BIT_WDT        4
`define RCF_BIT_EXT_PIN    3
`define RCF_BIT_OPCODE     2
`define RCF_BIT_POWERON    1
`define RCF_BIT_BROWNOUT   0

// implemented bits of reset_cause_register (bit 5 reads zero)
`define RCF_CAUSE_MASK     8'hDF

// value after power-on: stack flags 0, active-low flags 1, power-on flag 0,
// brown-out flag undefined in hardware and taken as 1 here
`define RCF_CAUSE_RST      8'h1D

// event status bit positions (one per reset source)
`define RCF_EVT_POWERON    0
`define RCF_EVT_BROWNOUT   1
`define RCF_EVT_OPCODE     2
`define RCF_EVT_EXT_PIN    3
`define RCF_EVT_WDT        4
`define RCF_EVT_STK_LOW    5
`define RCF_EVT_STK_HIGH   6
`define RCF_EVT_WIDTH      7

`define RCF_EVT_STATUS_RST 7'h00
`define RCF_EVT_MASK_RST   7'h00

`endif

// ===== rcf_reset_cause.v
// Summary of operation
// - one flag per reset source: power-on, brown-out, opcode, pin, watchdog, stack faults
// - a pin, opcode, watchdog or stack reset updates only the flag of its own cause; others keep value
// - hardware never returns the power-on or brown-out flag inactive; firmware writes it back after restart
// - software writes setting flags active are stored and readable, starting no reset
// - bit7 stack high, bit6 stack low, bit5 zero, bits4..0 wdt,pin,opcode,poweron,brownout
// - stack flags active high, set by their fault, cleared by power-on or brown-out
// - watchdog flag active low, cleared by timeout, set to one by power-on or brown-out
// - pin flag active low, cleared by pin reset, set by power-on or brown-out
// - opcode flag active low, cleared by reset instruction, set by power-on or brown-out
// - power-on flag reads zero after power-on reset, firmware re-arms by writing one
// - brown-out flag reads zero after brown-out reset, firmware re-arms by writing one
//
// Register access over APB and the register addresses were chosen for this implementation.
`include "rcf_consts.vh"

module rcf_reset_cause (
   // clock and power-on reset
   input  wire        clk,
   input  wire        arst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // one-cycle cause pulses from the reset sequencer (same clock)
   input  wire        porEvent,
   input  wire        borEvent,
   input  wire        opcodeEvent,
   input  wire        extPinEvent,
   input  wire        wdtEvent,
   input  wire        stkLowEvent,
   input  wire        stkHighEvent,
   // status towards the core
   output wire [7:0]  causeFlags,
   output wire        irq
);

   reg  [7:0]                 causeFf;
   reg  [7:0]                 nxt_cause;
   reg  [`RCF_EVT_WIDTH-1:0]  evtStatusFf;
   reg  [`RCF_EVT_WIDTH-1:0]  evtMaskFf;
   reg  [`RCF_EVT_WIDTH-1:0]  rdClrFf;
   reg  [`RCF_EVT_WIDTH-1:0]  nxt_evtStatus;
   reg  [31:0]                nxt_prdata;
   reg                        nxt_pslverr;
   reg                        nxt_rdClrArm;
   reg                        rdClrArmFf;

   wire                       setupPh;
   wire                       accessPh;
   wire                       wrCause;
   wire                       wrMask;
   wire [`RCF_EVT_WIDTH-1:0]  evtIn;

   function addrHit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         addrHit = (a == ofs);
      end
   endfunction

   function mapped;
      input [11:0] a;
      begin
         mapped = addrHit(a, `RCF_OFS_CAUSE) | addrHit(a, `RCF_OFS_EVT_STATUS) |
                  addrHit(a, `RCF_OFS_EVT_MASK);
      end
   endfunction

   assign setupPh  = psel & ~penable;
   assign accessPh = psel & penable;
   // zero wait states: read data and error are already registered in setup
   assign pready   = 1'b1;
   assign wrCause  = accessPh & pwrite & pstrb[0] & addrHit(paddr, `RCF_OFS_CAUSE);
   assign wrMask   = accessPh & pwrite & pstrb[0] & addrHit(paddr, `RCF_OFS_EVT_MASK);

   assign evtIn = {stkHighEvent, stkLowEvent, wdtEvent, extPinEvent,
                   opcodeEvent, borEvent, porEvent};

   // cause register: software write first, hardware causes laid on top
   always @* begin
      nxt_cause = causeFf;
      if (wrCause) begin
         nxt_cause = pwdata[7:0] & `RCF_CAUSE_MASK;
      end
      if (porEvent) begin
         nxt_cause[`RCF_BIT_STK_HIGH] = 1'b0;
         nxt_cause[`RCF_BIT_STK_LOW]  = 1'b0;
         nxt_cause[`RCF_BIT_WDT]      = 1'b1;
         nxt_cause[`RCF_BIT_EXT_PIN]  = 1'b1;
         nxt_cause[`RCF_BIT_OPCODE]   = 1'b1;
         nxt_cause[`RCF_BIT_POWERON]  = 1'b0;
      end
      if (borEvent) begin
         nxt_cause[`RCF_BIT_STK_HIGH] = 1'b0;
         nxt_cause[`RCF_BIT_STK_LOW]  = 1'b0;
         nxt_cause[`RCF_BIT_WDT]      = 1'b1;
         nxt_cause[`RCF_BIT_EXT_PIN]  = 1'b1;
         nxt_cause[`RCF_BIT_OPCODE]   = 1'b1;
         nxt_cause[`RCF_BIT_BROWNOUT] = 1'b0;
      end
      // single-cause updates leave every other flag alone
      if (opcodeEvent) begin
         nxt_cause[`RCF_BIT_OPCODE]   = 1'b0;
      end
      if (extPinEvent) begin
         nxt_cause[`RCF_BIT_EXT_PIN]  = 1'b0;
      end
      if (wdtEvent) begin
         nxt_cause[`RCF_BIT_WDT]      = 1'b0;
      end
      if (stkHighEvent) begin
         nxt_cause[`RCF_BIT_STK_HIGH] = 1'b1;
      end
      if (stkLowEvent) begin
         nxt_cause[`RCF_BIT_STK_LOW]  = 1'b1;
      end
      nxt_cause[`RCF_BIT_UNUSED] = 1'b0;
   end

   // event status: only bits captured in the setup read are cleared, so an
   // event landing between setup and access survives the read
   always @* begin
      nxt_evtStatus = evtStatusFf;
      if (rdClrArmFf && accessPh) begin
         nxt_evtStatus = evtStatusFf & ~rdClrFf;
      end
      nxt_evtStatus = nxt_evtStatus | evtIn;
   end

   // read data and error are sampled in the setup phase
   always @* begin
      nxt_prdata   = prdata;
      nxt_pslverr  = pslverr;
      nxt_rdClrArm = 1'b0;
      if (setupPh) begin
         nxt_prdata  = 32'h0000_0000;
         nxt_pslverr = ~mapped(paddr);
         if (!pwrite) begin
            if (addrHit(paddr, `RCF_OFS_CAUSE)) begin
               nxt_prdata[7:0] = causeFf;
            end else if (addrHit(paddr, `RCF_OFS_EVT_STATUS)) begin
               nxt_prdata[`RCF_EVT_WIDTH-1:0] = evtStatusFf;
               nxt_rdClrArm = 1'b1;
            end else if (addrHit(paddr, `RCF_OFS_EVT_MASK)) begin
               nxt_prdata[`RCF_EVT_WIDTH-1:0] = evtMaskFf;
            end
         end
      end else if (accessPh) begin
         nxt_rdClrArm = 1'b0;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         causeFf     <= `RCF_CAUSE_RST;
         evtStatusFf <= `RCF_EVT_STATUS_RST;
         evtMaskFf   <= `RCF_EVT_MASK_RST;
         rdClrFf     <= `RCF_EVT_STATUS_RST;
         rdClrArmFf  <= 1'b0;
         prdata      <= 32'h0000_0000;
         pslverr     <= 1'b0;
      end else begin
         causeFf     <= nxt_cause;
         evtStatusFf <= nxt_evtStatus;
         if (wrMask) begin
            evtMaskFf <= pwdata[`RCF_EVT_WIDTH-1:0];
         end
         if (setupPh) begin
            rdClrFf <= evtStatusFf;
         end
         rdClrArmFf  <= nxt_rdClrArm;
         prdata      <= nxt_prdata;
         pslverr     <= nxt_pslverr;
      end
   end

   // a software write never reaches the sequencer: flags are output only
   assign causeFlags = causeFf;
   assign irq        = |(evtStatusFf & evtMaskFf);

endmodule

// ===== rcf_checker_sva.sv
`include "rcf_consts.vh"
module rcf_checker_sva (
   // clock, reset and bus
   input wire logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [3:0]  pstrb,
   // cause pulses and flags
   input wire logic        porEvent, borEvent, opcodeEvent, extPinEvent, wdtEvent,
   input wire logic        stkLowEvent, stkHighEvent,
   input wire logic [7:0]  causeFlags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire anyEv = porEvent | borEvent | opcodeEvent | extPinEvent | wdtEvent | stkLowEvent
                | stkHighEvent;
   wire wrCause = psel & penable & pwrite & (paddr == `RCF_OFS_CAUSE) & pstrb[0];
   sequence s_rdSetup;
      psel && !penable && !pwrite && paddr == `RCF_OFS_CAUSE;
   endsequence
   property p_bit5; causeFlags[5] == 1'b0; endproperty
   a_bit5: assert property (p_bit5) else $error("bit 5 set");
   property p_wdt; wdtEvent |=> !causeFlags[4]; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared");
   property p_pin; extPinEvent |=> !causeFlags[3]; endproperty
   a_pin: assert property (p_pin) else $error("pin flag not cleared");
   property p_op; opcodeEvent |=> !causeFlags[2]; endproperty
   a_op: assert property (p_op) else $error("opcode flag not cleared");
   property p_stk; stkHighEvent && !porEvent && !borEvent |=> causeFlags[7]; endproperty
   a_stk: assert property (p_stk) else $error("stack high flag not set");
   property p_por; porEvent && !stkHighEvent && !stkLowEvent |=> causeFlags[7:1] == 7'h0E;
   endproperty
   a_por: assert property (p_por) else $error("power-on update wrong");
   property p_bor; borEvent |=> causeFlags[0] == 1'b0 && causeFlags[7:6] == 2'b00; endproperty
   a_bor: assert property (p_bor) else $error("brown-out update wrong");
   property p_keep; !anyEv && !wrCause |=> $stable(causeFlags); endproperty
   a_keep: assert property (p_keep) else $error("flags changed unprompted");
   property p_wr; wrCause && !anyEv |=> causeFlags == (pwdata[7:0] & `RCF_CAUSE_MASK);
   endproperty
   a_wr: assert property (p_wr) else $error("written flags not stored");
   property p_rd; s_rdSetup |=> prdata == {24'h000000, $past(causeFlags)}; endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
endmodule

// ===== reset_cause_flag_register_test.sv
`include "rcf_consts.vh"
module reset_cause_flag_register_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [6:0]  ev;
   logic [7:0]  base;
   wire  [31:0] prdata;
   wire  [7:0]  causeFlags;
   wire         pready, pslverr, irq;
   int          fail_count, n_tests;
   rcf_reset_cause u_rcf_reset_cause (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .porEvent(ev[0]),
      .borEvent(ev[1]), .opcodeEvent(ev[2]), .extPinEvent(ev[3]), .wdtEvent(ev[4]),
      .stkLowEvent(ev[5]), .stkHighEvent(ev[6]), .causeFlags(causeFlags), .irq(irq));
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   // events in e land at the access edge, together with a write
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [6:0] e);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1; ev <= e;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0; ev <= 0;
   endtask
   task pulse(input int k);
      @(posedge clk);
      ev <= 7'h01 << k;
      @(posedge clk);
      ev <= 0;
   endtask
   function automatic logic [7:0] model(input int k, input logic [7:0] v);
      case (k)
         0: v = {2'b00, v[5], 3'b111, 1'b0, v[0]};
         1: v = {2'b00, v[5], 3'b111, v[1], 1'b0};
         2: v[2] = 0;
         3: v[3] = 0;
         4: v[4] = 0;
         5: v[6] = 1;
         default: v[7] = 1;
      endcase
      return v;
   endfunction
   task t_resetValues;
      apb(0, `RCF_OFS_CAUSE, 0, 0); chk("cause", rd, 32'h1D);
      apb(0, `RCF_OFS_EVT_MASK, 0, 0); chk("mask", rd, 0);
      apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 0);
      chk("irq", irq, 0);
   endtask
   task t_write;
      apb(1, `RCF_OFS_CAUSE, 32'hFF, 0);
      apb(0, `RCF_OFS_CAUSE, 0, 0); chk("cause", rd, 32'hDF);
      chk("flags", causeFlags, 32'hDF);
      apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 0);
   endtask
   task t_eachCause;
      for (int k = 0; k < 7; k++) begin
         base = (k > 4) ? 8'h1F : 8'hDF;
         apb(1, `RCF_OFS_CAUSE, base, 0);
         pulse(k);
         apb(0, `RCF_OFS_CAUSE, 0, 0); chk("cause", rd, model(k, base));
         chk("flags", causeFlags, model(k, base));
         apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 32'h1 << k);
         apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 0);
      end
   endtask
   task t_collide;
      apb(1, `RCF_OFS_CAUSE, 32'hFF, 7'h10);
      apb(0, `RCF_OFS_CAUSE, 0, 0); chk("cause", rd, 32'hCF);
      apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 32'h10);
   endtask
   task t_irq;
      apb(1, `RCF_OFS_EVT_MASK, 32'h10, 0);
      pulse(4); @(negedge clk); chk("irq", irq, 1);
      apb(0, `RCF_OFS_EVT_STATUS, 0, 0); @(negedge clk); chk("irq", irq, 0);
      pulse(2); @(negedge clk); chk("irq", irq, 0);
      apb(0, `RCF_OFS_EVT_STATUS, 0, 0); chk("status", rd, 32'h04);
   endtask
   task t_unmapped;
      apb(1, `RCF_OFS_CAUSE, 32'h1F, 0);
      apb(1, 12'h00C, 32'hFF, 0); chk("err", err, 1);
      apb(0, 12'h00C, 0, 0); chk("err", err, 1); chk("data", rd, 0);
      apb(0, `RCF_OFS_CAUSE, 0, 0); chk("cause", rd, 32'h1F);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      fail_count++;
      print_verdict();
   end
   initial begin
      arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ev = 0;
      repeat (5) @(posedge clk);
      arst_n <= 1;
      t_resetValues(); t_write(); t_eachCause(); t_collide(); t_irq(); t_unmapped();
      print_verdict();
   end
endmodule
bind rcf_reset_cause rcf_checker_sva u_rcf_checker_sva (.clk(clk), .arst_n(arst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
   .irq(irq), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
   .porEvent(porEvent), .borEvent(borEvent), .opcodeEvent(opcodeEvent),
   .extPinEvent(extPinEvent), .wdtEvent(wdtEvent), .stkLowEvent(stkLowEvent),
   .stkHighEvent(stkHighEvent), .causeFlags(causeFlags));
